// [verilog/adc_coding_regs.svh]
/*
 header of constants for the sample output coding block: widths, pipeline
 depth, code words. assumes inclusion by bare name from design files.
*/
`ifndef ADC_CODING_REGS_SVH
`define ADC_CODING_REGS_SVH

`define SAMPLE_WIDTH        12
`define PIPE_LATENCY        5
`define SAMPLE_MSB_POS      11
`define CODE_POS_FULL       12'hfff
`define CODE_BIPOLAR_ZERO   12'h800
`define CODE_NEG_FULL       12'h000
`define CODE_POS_HALF       12'hc00
`define CODE_NEG_HALF       12'h400
`define SAMPLE_RESET_VALUE  12'h000
`define MIN_SAMPLE_RATE_HZ  1000000
`define SYS_CLK_HZ          25000000
`define DUTY_LIMIT_RATE_HZ  50000000

`endif

// [verilog/adc_coding_pkg.sv]
/*
 types shared by the coding block. assumes the constants header is on the
 include path.
*/
`include "adc_coding_regs.svh"

package adc_coding_pkg;

    typedef enum logic {
        offset_binary_code,
        twos_complement_code
    } code_format_t;

    typedef struct packed {
        logic [`SAMPLE_WIDTH-1:0] word;
        logic                     valid;
    } sample_t;

endpackage

// [verilog/adc_code_format.sv]
/*
 converts an offset binary sample word into the selected output format.
 assumes the word arrives registered; the result is combinational.
*/
`timescale 1ns/10ps
`include "adc_coding_regs.svh"

module adc_code_format #(
    parameter int WIDTH = `SAMPLE_WIDTH
) (
    // sample in
    input  wire logic [WIDTH-1:0] offset_word_in,
    input  wire logic             code_format_select_in,
    // formatted sample
    output logic      [WIDTH-1:0] coded_word_out
);

    initial begin
        if (WIDTH < 2) begin
            $error("adc_code_format: WIDTH must be at least 2");
        end
    end

    // only the top bit differs between the formats
    assign coded_word_out = {offset_word_in[WIDTH-1] ^ code_format_select_in,
                             offset_word_in[WIDTH-2:0]};

endmodule

// [verilog/adc_output_coding_control.sv]
/*
 digital back end of a pipelined sampling converter: carries quantised words
 through a fixed-latency pipeline, applies output coding, gates the data pins
 and handles power-down. assumes the quantiser word arrives in offset binary
 once per sampling clock and that the sampling clock is this block's clock.
*/
`timescale 1ns/10ps
`include "adc_coding_regs.svh"

// Operation
// - high select gives two's complement, low offset
// - formats differ only in inverted top bit
// - offset binary full scale and zero codes
// - half scale codes swap between formats
// - enable low drives data, high floats it
// - power-down stops converter, reference stays up
// - power-down flushes pipeline, full latency after
// - pipeline advances one step per clock
// - output word lags its sample six cycles
module adc_output_coding_control #(
    parameter int WIDTH   = `SAMPLE_WIDTH,
    parameter int LATENCY = `PIPE_LATENCY
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic             clk_en_in,
    // quantiser side
    input  wire logic [WIDTH-1:0] sample_word_in,
    // control pins
    input  wire logic             code_format_select_in,
    input  wire logic             output_enable_n_in,
    input  wire logic             power_down_request_in,
    // data pins
    output logic      [WIDTH-1:0] data_out,
    output logic      [WIDTH-1:0] data_oe_out,
    output logic                  data_valid_out,
    // power status
    output logic                  core_active_out,
    output logic                  reference_active_out
);

    localparam int MIN_HZ = `MIN_SAMPLE_RATE_HZ;
    localparam int CLK_HZ = `SYS_CLK_HZ;

    initial begin
        if (WIDTH != `SAMPLE_WIDTH) begin
            $error("adc_output_coding_control: WIDTH must be 12");
        end
        if (LATENCY < 2) begin
            $error("adc_output_coding_control: LATENCY must be at least 2");
        end
        // the partner must keep the sampling clock above the droop limit
        if (CLK_HZ < MIN_HZ) begin
            $error("adc_output_coding_control: clock below minimum sample rate");
        end
    end

    adc_coding_pkg::sample_t pipe [LATENCY];
    logic [WIDTH-1:0]         coded_word;
    logic                     powered_down;

    // power-down is a plain level; the pin is held low when unused
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            powered_down <= 1'b0;
        end else if (clk_en_in) begin
            powered_down <= power_down_request_in;
        end
    end

    // each stage steps once per clock; power-down empties every stage so no
    // stale sample survives, and refill takes the full latency
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe[i] <= '0;
            end
        end else if (clk_en_in) begin
            if (power_down_request_in || powered_down) begin
                for (int i = 0; i < LATENCY; i++) begin
                    pipe[i] <= '0;
                end
            end else begin
                pipe[0].word  <= sample_word_in;
                pipe[0].valid <= 1'b1;
                for (int i = 1; i < LATENCY; i++) begin
                    pipe[i] <= pipe[i-1];
                end
            end
        end
    end

    adc_code_format #(
        .WIDTH(WIDTH)
    ) u_format (
        .offset_word_in        (pipe[LATENCY-1].word),
        .code_format_select_in (code_format_select_in),
        .coded_word_out        (coded_word)
    );

    // output register: the sixth stage, after the five pipeline stages, with coding applied on the way in
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_out       <= `SAMPLE_RESET_VALUE;
            data_valid_out <= 1'b0;
        end else if (clk_en_in) begin
            data_out       <= coded_word;
            data_valid_out <= pipe[LATENCY-1].valid;
        end
    end

    // enable is used as a level; toggling it fast is the partner's fault
    assign data_oe_out = {WIDTH{~output_enable_n_in}};

    assign core_active_out      = ~powered_down;
    assign reference_active_out = 1'b1;

endmodule

// [verification/adc_coding_asserts.sv]
/* checker for the coding block; bound to its top module */
`timescale 1ns/10ps
module adc_coding_asserts #(parameter int WIDTH = 12) (
    input wire logic             sys_clk_in, rst_in, clk_en_in, code_format_select_in,
    input wire logic             output_enable_n_in, power_down_request_in,
    input wire logic [WIDTH-1:0] sample_word_in, data_out, data_oe_out,
    input wire logic             data_valid_out, core_active_out, reference_active_out);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    a_oe_drive: assert property (!output_enable_n_in |-> &data_oe_out) else $error("oe");
    a_oe_float: assert property (output_enable_n_in |-> ~|data_oe_out) else $error("hz");
    a_ref_up: assert property (reference_active_out) else $error("ref");
    a_core_down: assert property (power_down_request_in |=> !core_active_out) else $error("pd");
    a_low_bits: assert property (data_valid_out |->
        data_out[WIDTH-2:0] == $past(sample_word_in[WIDTH-2:0], 6)) else $error("lag");
    a_top_bit: assert property (data_valid_out |-> data_out[WIDTH-1] ==
        ($past(sample_word_in[WIDTH-1], 6) ^ $past(code_format_select_in))) else $error("msb");
    a_pd_flush: assert property ($rose(power_down_request_in) |-> ##[1:6] !data_valid_out)
        else $error("flush");
    a_pd_wake: assert property ($fell(power_down_request_in) |=> !data_valid_out[*5])
        else $error("wake");
    c_twos: cover property (data_valid_out && code_format_select_in);
    c_wake: cover property ($fell(power_down_request_in));
    c_float: cover property (output_enable_n_in);
endmodule
bind adc_output_coding_control adc_coding_asserts #(.WIDTH(WIDTH)) chk_i (.sys_clk_in, .rst_in,
    .clk_en_in, .code_format_select_in, .output_enable_n_in, .power_down_request_in,
    .sample_word_in, .data_out, .data_oe_out, .data_valid_out, .core_active_out,
    .reference_active_out);

// [verification/sample_capture.sv]
/* capture logic on the data pins; a floated pin reads as the flipped last value */
`timescale 1ns/10ps
module sample_capture (
    input wire logic        sys_clk_in,
    input wire logic [11:0] pin_in, oe_in,
    input wire logic        valid_in,
    output logic     [11:0] cap_out,
    output logic            cap_valid_out);
    always_ff @(posedge sys_clk_in) begin
        cap_out <= (pin_in & oe_in) | (~cap_out & ~oe_in);
        cap_valid_out <= valid_in & (&oe_in);
    end
endmodule

// [verification/tb_top.sv]
/* bench for the coding block: pipeline model, capture partner; clock enable held high */
`timescale 1ns/10ps
module tb_top;
    logic clk = 0, rst = 1, sel = 0, oe_n = 0, pd = 0, pd_q, ev, pv, dv, core, refa, capv;
    logic [11:0] smp = 12'h000, dout, doe, cap, ew, pw;
    logic [4:0][11:0] mw;
    logic [4:0] mv;
    int err_total = 0, num_checks = 0, cyc = 0;
    logic [11:0] codes[5] = '{12'hfff, 12'h800, 12'h000, 12'hc00, 12'h400};
    always #20 clk = ~clk;
    adc_output_coding_control adc_output_coding_control_i (.sys_clk_in(clk),
        .rst_in(rst), .clk_en_in(1'b1), .sample_word_in(smp), .code_format_select_in(sel),
        .output_enable_n_in(oe_n), .power_down_request_in(pd), .data_out(dout),
        .data_oe_out(doe), .data_valid_out(dv), .core_active_out(core),
        .reference_active_out(refa));
    sample_capture sample_capture_i (.sys_clk_in(clk), .pin_in(dout), .oe_in(doe),
        .valid_in(dv), .cap_out(cap), .cap_valid_out(capv));
    task automatic chk(input logic [11:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // reference pipeline: a pin-low edge still clears, matching the one-cycle wake delay
    always @(posedge clk) begin
        if (rst) begin
            mv = 0;
            pd_q = 0;
            ev = 0;
        end else begin
            pv = ev;
            pw = ew;
            ev = mv[4];
            ew = {mw[4][11] ^ sel, mw[4][10:0]};
            mv = (pd || pd_q) ? 5'h00 : {mv[3:0], 1'b1};
            mw = {mw[3:0], smp};
            pd_q = pd;
        end
    end
    always @(negedge clk) if (!rst) begin
        chk(12'(dv), 12'(ev));
        if (ev) chk(dout, ew);
        chk(doe, oe_n ? 12'h000 : 12'hfff);
        if (capv) chk(cap, pw);
        chk(12'(core), 12'(!pd_q));
        chk(12'(refa), 12'h001);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'hd344a08a));
        repeat (5) @(posedge clk);
        rst <= 0;
        for (int t = 0; t < 4; t++) begin
            for (int i = 0; i < 80; i++) begin
                @(posedge clk);
                smp <= (t == 1) ? codes[i % 5] : 12'($urandom);
                sel <= (t == 1) ? 1'((i / 5) % 2) : 1'($urandom);
                pd <= (t == 2 && i % 13 < 3);
                oe_n <= (t == 3 && i % 16 > 7);
            end
            $display("test %0d done, errors %0d", t, err_total);
        end
        repeat (8) @(posedge clk);
        print_verdict();
    end
endmodule
